// file: tws_pkg.sv
package tws_pkg;

  // register indices on the plain port
  localparam logic [2:0] TWS_OFF_DATA   = 3'h0;
  localparam logic [2:0] TWS_OFF_ADDR   = 3'h1;
  localparam logic [2:0] TWS_OFF_CTRL   = 3'h2;
  localparam logic [2:0] TWS_OFF_STATUS = 3'h3;

  // control register bit positions
  localparam int TWS_CTRL_DONE  = 7;
  localparam int TWS_CTRL_ACKEN = 6;
  localparam int TWS_CTRL_START = 5;
  localparam int TWS_CTRL_STOP  = 4;
  localparam int TWS_CTRL_WCOL  = 3;
  localparam int TWS_CTRL_EN    = 2;
  localparam int TWS_CTRL_IRQEN = 0;

  // address configuration register bit positions
  localparam int TWS_ADDR_GCE = 0;

  // reset values
  localparam logic [7:0] TWS_RST_DATA = 8'hFF;
  localparam logic [7:0] TWS_RST_ADDR = 8'hFE;
  localparam logic [7:0] TWS_RST_CTRL = 8'h00;
  localparam logic [1:0] TWS_RST_PRE  = 2'h0;

  // status codes, prescaler bits zero
  localparam logic [7:0] TWS_ST_BUSERR  = 8'h00;
  localparam logic [7:0] TWS_ST_SR_ADDR = 8'h60;
  localparam logic [7:0] TWS_ST_SR_ARB  = 8'h68;
  localparam logic [7:0] TWS_ST_GC_ADDR = 8'h70;
  localparam logic [7:0] TWS_ST_GC_ARB  = 8'h78;
  localparam logic [7:0] TWS_ST_SR_ACK  = 8'h80;
  localparam logic [7:0] TWS_ST_SR_NACK = 8'h88;
  localparam logic [7:0] TWS_ST_GC_ACK  = 8'h90;
  localparam logic [7:0] TWS_ST_GC_NACK = 8'h98;
  localparam logic [7:0] TWS_ST_STOP    = 8'hA0;
  localparam logic [7:0] TWS_ST_ST_ADDR = 8'hA8;
  localparam logic [7:0] TWS_ST_ST_ARB  = 8'hB0;
  localparam logic [7:0] TWS_ST_ST_ACK  = 8'hB8;
  localparam logic [7:0] TWS_ST_ST_NACK = 8'hC0;
  localparam logic [7:0] TWS_ST_ST_LAST = 8'hC8;
  localparam logic [7:0] TWS_ST_NONE    = 8'hF8;
  localparam logic [7:0] TWS_GC_ADDRESS = 8'h00;

  // bit counter landmarks within one byte frame
  localparam logic [3:0] TWS_CNT_ACK = 4'h8;
  localparam logic [3:0] TWS_CNT_END = 4'h9;

  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_RX   = 3'b011,
    TWS_TX   = 3'b010,
    TWS_ERR  = 3'b110
  } tws_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tws_reg_req_t;

endpackage

// file: tws_slave.sv
// Function
// R1: after general-call data acked, next byte gets ACK if ack enable set, else NACK.
// R2: after general-call data nacked and flag clear, go not-addressed; ack enable gates matching.
// R3: stop or repeated start while addressed reports status; flag clear enters not-addressed; code reports it only in receive mode, not in transmit.
// R4: not-addressed with ack enable: own address matched, general call only if enabled.
// R5: start request set on leaving addressed state requests a start once bus free.
// R6: upper seven address config bits compared against received slave address.
// R7: address config bit zero enables answering the all-zero general call address.
// R8: software arms slave with enable and ack enable one, other control bits zero.
// R9: after own address match, read bit selects transmit mode, write bit receive mode.
// R10: after address and direction received, done flag set with valid status code.
// R11: addressed for read after lost arbitration enters transmit with its own status.
// R12: ack enable cleared in transmit sends one last byte; nack and ack give two codes.
// R13: after final byte, not-addressed; master clocking ignored and reads all ones.
// R14: ack enable zero stops address answers; bus still watched, resumes when set.
// R15: in deep sleep with ack enable, address still acknowledged and wake-up raised.
// R16: after wake-up, bus clock held low until software writes one to done flag.
// R17: after sleep wake-up, data register need not hold the last bus byte.
// R18: status codes defined with prescaler bits zero; software masks them.
// R19: own write address acked reports status, then receives data per ack enable.
// R20: in transmit, data register byte sent; ack enable zero marks it last.
// R21: misplaced start or stop gives bus error; stop request plus flag clear recovers silently; code raises it in receive or transmit only.
// R22: while done flag set, status stays stable and bus clock is stretched low; code holds the clock only after a byte, not after stop or bus error.
module tws_slave
  import tws_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire tws_reg_req_t reg_req_i,
  output logic [7:0]        rdata_o,
  input  wire logic         scl_i,
  output logic              scl_o,
  output logic              scl_oe_o,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe_o,
  input  wire logic         arb_lost_i,
  input  wire logic         deep_sleep_i,
  output logic              wake_o,
  output logic              start_go_o,
  output logic              irq_o
);

  // pin synchronisers
  logic       scl_s1, scl_s2, scl_s3;
  logic       sda_s1, sda_s2, sda_s3;
  // registers
  logic [7:0] data_reg;
  logic [7:0] addr_cfg;
  logic       ack_en, start_req, stop_req, wcol, iface_en, irq_en;
  logic [1:0] prescale;
  logic       done_flag;
  logic [7:0] status_code;
  // shifter and framing
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic       ack_seen;
  logic       bus_busy;
  // slave state
  tws_state_t state;
  logic       is_gc, acked, last_byte, hold, start_pend;
  logic [7:0] tx_byte;
  logic       sda_low;

  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic wr_ctrl, wr_data, flag_clr, addr_hit, gc_hit, mid_byte, active;

  function automatic logic leaves_addressed(input logic [7:0] code);
    return code == TWS_ST_SR_NACK || code == TWS_ST_GC_NACK || code == TWS_ST_STOP
        || code == TWS_ST_ST_NACK || code == TWS_ST_ST_LAST;
  endfunction

  function automatic logic tx_load(input logic [7:0] code);
    return code == TWS_ST_ST_ADDR || code == TWS_ST_ST_ARB || code == TWS_ST_ST_ACK;
  endfunction

  assign scl_rise  = scl_s2 && !scl_s3;
  assign scl_fall  = !scl_s2 && scl_s3;
  assign bus_start = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
  assign bus_stop  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;

  assign wr_ctrl  = reg_req_i.wr && reg_req_i.addr == TWS_OFF_CTRL;
  assign wr_data  = reg_req_i.wr && reg_req_i.addr == TWS_OFF_DATA;
  assign flag_clr = wr_ctrl && reg_req_i.wdata[TWS_CTRL_DONE] && done_flag; // see R16

  // address match, gated by ack enable
  assign addr_hit = ack_en && shift[7:1] == addr_cfg[7:1]; // see R6 see R14
  assign gc_hit   = ack_en && addr_cfg[TWS_ADDR_GCE] && shift == TWS_GC_ADDRESS; // see R4 see R7
  // the clock rise that precedes a stop or repeated start counts one bit
  assign mid_byte = bit_cnt > 4'h1;
  assign active   = state == TWS_ADDR || state == TWS_RX || state == TWS_TX;

  // two-flop synchronisers plus an edge-history flop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else if (ce_i) begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // bus busy between start and stop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_busy <= 1'b0;
    end else if (ce_i) begin
      if (bus_start) begin
        bus_busy <= 1'b1;
      end else if (bus_stop) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shift    <= 8'h00;
      bit_cnt  <= 4'h0;
      ack_seen <= 1'b0;
    end else if (ce_i) begin
      if (bus_start || bus_stop) begin
        bit_cnt <= 4'h0;
      end else if (scl_rise && active) begin
        if (bit_cnt < TWS_CNT_ACK) begin
          shift   <= {shift[6:0], sda_s2};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bit_cnt == TWS_CNT_ACK) begin
          ack_seen <= !sda_s2;
          bit_cnt  <= TWS_CNT_END;
        end
      end else if (scl_fall && bit_cnt == TWS_CNT_END) begin
        bit_cnt <= 4'h0;
      end
    end
  end

  // software-owned control bits and address config
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_cfg  <= TWS_RST_ADDR;
      ack_en    <= TWS_RST_CTRL[TWS_CTRL_ACKEN];
      start_req <= TWS_RST_CTRL[TWS_CTRL_START];
      stop_req  <= TWS_RST_CTRL[TWS_CTRL_STOP];
      iface_en  <= TWS_RST_CTRL[TWS_CTRL_EN];
      irq_en    <= TWS_RST_CTRL[TWS_CTRL_IRQEN];
      prescale  <= TWS_RST_PRE;
      wcol      <= TWS_RST_CTRL[TWS_CTRL_WCOL];
    end else if (ce_i) begin
      if (reg_req_i.wr && reg_req_i.addr == TWS_OFF_ADDR) begin
        addr_cfg <= reg_req_i.wdata;
      end
      if (reg_req_i.wr && reg_req_i.addr == TWS_OFF_STATUS) begin
        prescale <= reg_req_i.wdata[1:0];
      end
      if (wr_ctrl) begin
        ack_en    <= reg_req_i.wdata[TWS_CTRL_ACKEN];
        start_req <= reg_req_i.wdata[TWS_CTRL_START];
        stop_req  <= reg_req_i.wdata[TWS_CTRL_STOP];
        iface_en  <= reg_req_i.wdata[TWS_CTRL_EN];
        irq_en    <= reg_req_i.wdata[TWS_CTRL_IRQEN];
        // recovery consumes the stop request without a stop on the bus
        if (flag_clr && status_code == TWS_ST_BUSERR) begin
          stop_req <= 1'b0; // see R21
        end
      end
      if (wr_data) begin
        wcol <= !done_flag;
      end
    end
  end

  // data register: software writes only while flag set
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_reg <= TWS_RST_DATA;
    end else if (ce_i) begin
      if (wr_data && done_flag) begin
        data_reg <= reg_req_i.wdata;
      end else if (scl_fall && bit_cnt == TWS_CNT_END && state == TWS_RX) begin
        data_reg <= shift;
      end
    end
  end

  // slave state machine, done flag and status
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state       <= TWS_IDLE;
      done_flag   <= 1'b0;
      status_code <= TWS_ST_NONE;
      is_gc       <= 1'b0;
      acked       <= 1'b0;
      last_byte   <= 1'b0;
      hold        <= 1'b0;
      tx_byte     <= 8'hFF;
      sda_low     <= 1'b0;
      wake_o      <= 1'b0;
    end else if (ce_i) begin
      // software clear first so that a same-cycle set below wins
      if (flag_clr) begin
        done_flag <= 1'b0;
        hold      <= 1'b0;
        wake_o    <= 1'b0; // see R16
        if (leaves_addressed(status_code)) begin
          state   <= TWS_IDLE; // see R2 see R3 see R13
          sda_low <= 1'b0;
        end else if (status_code == TWS_ST_BUSERR && reg_req_i.wdata[TWS_CTRL_STOP]) begin
          state   <= TWS_IDLE; // see R21
          sda_low <= 1'b0;
        end else if (tx_load(status_code)) begin
          tx_byte   <= data_reg; // see R20
          last_byte <= !reg_req_i.wdata[TWS_CTRL_ACKEN]; // see R12
          sda_low   <= !data_reg[7];
        end
      end
      if (!iface_en) begin
        state   <= TWS_IDLE;
        sda_low <= 1'b0;
        hold    <= 1'b0;
      end else if (bus_start || bus_stop) begin
        sda_low <= 1'b0;
        if (active && mid_byte && state != TWS_ADDR) begin
          state       <= TWS_ERR;
          done_flag   <= 1'b1; // see R21
          status_code <= TWS_ST_BUSERR;
          hold        <= 1'b0;
        end else begin
          if (state == TWS_RX) begin
            done_flag   <= 1'b1; // see R3
            status_code <= TWS_ST_STOP;
            hold        <= 1'b0;
          end
          // watching continues regardless of ack enable
          state <= bus_start ? TWS_ADDR : TWS_IDLE; // see R14
        end
      end else if (scl_fall && state != TWS_IDLE && state != TWS_ERR) begin
        case (bit_cnt)
          TWS_CNT_ACK: begin
            if (state == TWS_ADDR) begin
              if (addr_hit || gc_hit) begin
                sda_low <= 1'b1;
                is_gc   <= gc_hit && !addr_hit;
                if (deep_sleep_i) begin
                  wake_o <= 1'b1; // see R15
                end
              end else begin
                state <= TWS_IDLE;
              end
            end else if (state == TWS_RX) begin
              sda_low <= ack_en; // see R1 see R19
              acked   <= ack_en;
            end else begin
              sda_low <= 1'b0;
            end
          end
          TWS_CNT_END: begin
            sda_low   <= 1'b0;
            done_flag <= 1'b1; // see R10
            hold      <= 1'b1; // see R22
            case (state)
              TWS_ADDR: begin
                if (shift[0] && !is_gc) begin
                  state       <= TWS_TX; // see R9
                  status_code <= arb_lost_i ? TWS_ST_ST_ARB : TWS_ST_ST_ADDR; // see R11
                end else begin
                  state <= TWS_RX;
                  if (is_gc) begin
                    status_code <= arb_lost_i ? TWS_ST_GC_ARB : TWS_ST_GC_ADDR;
                  end else begin
                    status_code <= arb_lost_i ? TWS_ST_SR_ARB : TWS_ST_SR_ADDR; // see R19
                  end
                end
              end
              TWS_RX: begin
                if (is_gc) begin
                  status_code <= acked ? TWS_ST_GC_ACK : TWS_ST_GC_NACK; // see R1 see R2
                end else begin
                  status_code <= acked ? TWS_ST_SR_ACK : TWS_ST_SR_NACK;
                end
              end
              TWS_TX: begin
                if (!ack_seen) begin
                  status_code <= TWS_ST_ST_NACK; // see R12
                end else begin
                  status_code <= last_byte ? TWS_ST_ST_LAST : TWS_ST_ST_ACK; // see R12
                end
              end
              default: begin
                status_code <= TWS_ST_BUSERR;
              end
            endcase
          end
          default: begin
            // shift out next data bit while clock is low
            if (state == TWS_TX && bit_cnt < TWS_CNT_ACK) begin
              sda_low <= !tx_byte[3'd7 - bit_cnt[2:0]];
            end
          end
        endcase
      end
    end
  end

  // start requested on leaving an addressed state, issued once bus free
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      start_pend <= 1'b0;
    end else if (ce_i) begin
      if (flag_clr && leaves_addressed(status_code) && reg_req_i.wdata[TWS_CTRL_START]) begin
        start_pend <= 1'b1; // see R5
      end else if (start_pend && !bus_busy) begin
        start_pend <= 1'b0;
      end
    end
  end

  assign start_go_o = start_pend && !bus_busy && ce_i; // see R5

  // read port: data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (reg_req_i.rd) begin
        case (reg_req_i.addr)
          TWS_OFF_DATA:   rdata_o <= data_reg; // see R17
          TWS_OFF_ADDR:   rdata_o <= addr_cfg;
          TWS_OFF_CTRL:   rdata_o <= {done_flag, ack_en, start_req, stop_req,
                                      wcol, iface_en, 1'b0, irq_en};
          // code bits never overlap the prescaler field
          TWS_OFF_STATUS: rdata_o <= {(done_flag ? status_code[7:3] : TWS_ST_NONE[7:3]),
                                      1'b0, prescale}; // see R18 see R22
          default:        rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // open-drain pins: only ever pull low
  assign scl_o    = 1'b0;
  assign scl_oe_o = hold && done_flag && iface_en; // see R16 see R22
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_low && iface_en; // see R13
  assign irq_o    = irq_en && done_flag;

endmodule // tws_slave

// file: tws_slave_asserts.sv
module tws_slave_asserts
  import tws_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         reset_i,
  input wire logic         ce_i,
  input wire tws_reg_req_t reg_req_i,
  input wire logic [7:0]   rdata_o,
  input wire logic         scl_i,
  input wire logic         scl_o,
  input wire logic         scl_oe_o,
  input wire logic         sda_i,
  input wire logic         sda_o,
  input wire logic         sda_oe_o,
  input wire logic         arb_lost_i,
  input wire logic         deep_sleep_i,
  input wire logic         wake_o,
  input wire logic         start_go_o,
  input wire logic         irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire ctl_wr = reg_req_i.wr && reg_req_i.addr == TWS_OFF_CTRL;

  a_pins_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain output level not low");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset_i |=> !scl_oe_o && !sda_oe_o && !wake_o && rdata_o == 8'h00)
    else $error("outputs active after reset");
  a_read_window: assert property (!reg_req_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_status_form: assert property (
    reg_req_i.rd && ce_i && reg_req_i.addr == TWS_OFF_STATUS |=> !rdata_o[2])
    else $error("status bit two not zero");
  a_stretch_hold: assert property (scl_oe_o && !ctl_wr |=> scl_oe_o)
    else $error("clock stretch dropped without flag clear");
  a_stretch_end: assert property ($fell(scl_oe_o) |-> $past(ctl_wr))
    else $error("clock released without control write");
  a_wake_hold: assert property (wake_o && !ctl_wr |=> wake_o)
    else $error("wake dropped without flag clear");
  a_wake_cause: assert property ($rose(wake_o) |-> $past(deep_sleep_i))
    else $error("wake raised outside sleep");
  a_start_frozen: assert property (!ce_i |-> !start_go_o)
    else $error("start request while frozen");
endmodule // tws_slave_asserts

bind tws_slave tws_slave_asserts tws_slave_asserts_inst (.clk_i, .reset_i, .ce_i,
  .reg_req_i, .rdata_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o,
  .arb_lost_i, .deep_sleep_i, .wake_o, .start_go_o, .irq_o);

// file: tws_master_model.sv
module tws_master_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task bus_start();
    sda_low_o = 1'b1;
    #80 scl_low_o = 1'b1;
  endtask
  task bus_stop();
    #23 sda_low_o = 1'b1;
    #97 scl_low_o = 1'b0;
    wait (scl_i);
    #40 sda_low_o = 1'b0;
    #80;
  endtask
  // one 160 ns bit, waits out a stretched clock
  task bit_io(input logic b, output logic r);
    #23 sda_low_o = !b;
    #97 scl_low_o = 1'b0;
    wait (scl_i);
    #20 r = sda_i;
    #20 scl_low_o = 1'b1;
  endtask
  // msb first, then the acknowledge bit
  task xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic sa);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ma, sa);
    #120;
  endtask
endmodule // tws_master_model

// file: tb.sv
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tws_pkg::*;
  typedef struct packed {
    logic w; logic [2:0] a; logic [7:0] d; logic [2:0] ra; logic [7:0] e;
  } tws_row_t;
  logic         clk_i, reset_i, ce_i, arb_lost_i, deep_sleep_i;
  tws_reg_req_t req;
  logic [7:0]   rdata_o, v, q;
  logic         scl_oe_o, sda_oe_o, wake_o, start_go_o, irq_o, ack, go_seen;
  wire          scl_i, sda_i, m_scl, m_sda;
  int           error_cnt, tests_run;
  tws_row_t     rows [8] = '{
    '{1'h0, 3'h0, 8'h00, 3'h0, 8'hFF}, '{1'h0, 3'h0, 8'h00, 3'h1, 8'hFE},
    '{1'h0, 3'h0, 8'h00, 3'h2, 8'h00}, '{1'h0, 3'h0, 8'h00, 3'h3, 8'hF8},
    '{1'h1, 3'h6, 8'h55, 3'h6, 8'h00}, '{1'h1, 3'h3, 8'h03, 3'h3, 8'hFB},
    '{1'h1, 3'h0, 8'h12, 3'h2, 8'h08}, '{1'h1, 3'h3, 8'h00, 3'h0, 8'hFF}};
  logic [7:0]   bad [3] = '{8'h00, 8'h56, 8'hD4};
  assign scl_i = !(m_scl | scl_oe_o);
  assign sda_i = !(m_sda | sda_oe_o);
  // start request lasts one cycle, so latch it
  always @(posedge clk_i) go_seen <= reset_i ? 1'b0 : (go_seen | start_go_o);

  tws_slave tws_slave_inst (.clk_i, .reset_i, .ce_i, .reg_req_i(req), .rdata_o, .scl_i,
    .scl_o(), .scl_oe_o, .sda_i, .sda_o(), .sda_oe_o, .arb_lost_i, .deep_sleep_i,
    .wake_o, .start_go_o, .irq_o);
  tws_master_model tws_master_model_inst (.scl_i, .sda_i, .scl_low_o(m_scl),
    .sda_low_o(m_sda));

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 v = rdata_o;
  endtask
  // status with prescaler bits masked
  task st(input logic [7:0] e);
    rd(TWS_OFF_STATUS);
    `CHK(v & 8'hF8, e)
  endtask
  task x(input logic [7:0] d, input logic ma);
    tws_master_model_inst.xfer(d, ma, q, ack);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #300us;
    error_cnt++;
    complete_run();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    {reset_i, ce_i, arb_lost_i, deep_sleep_i} = 4'b1100;
    req = '0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].ra);
      `CHK(v, rows[i].e)
    end
    wr(TWS_OFF_ADDR, 8'h55);
    wr(TWS_OFF_CTRL, 8'h45);
    tws_master_model_inst.bus_start();
    x(8'h54, 1'b1);
    `CHK(ack, 1'b0)
    st(TWS_ST_SR_ADDR);
    `CHK({irq_o, scl_oe_o}, 2'b11)
    wr(TWS_OFF_CTRL, 8'hC5);
    x(8'h3C, 1'b1);
    `CHK(ack, 1'b0)
    st(TWS_ST_SR_ACK);
    rd(TWS_OFF_DATA);
    `CHK(v, 8'h3C)
    wr(TWS_OFF_CTRL, 8'h85);
    x(8'h77, 1'b1);
    `CHK(ack, 1'b1)
    st(TWS_ST_SR_NACK);
    wr(TWS_OFF_CTRL, 8'hE5);
    st(TWS_ST_NONE);
    `CHK(start_go_o, 1'b0)
    `CHK(go_seen, 1'b0)
    tws_master_model_inst.bus_stop();
    `CHK(go_seen, 1'b1)
    ce_i <= 1'b0;
    @(posedge clk_i);
    #1 `CHK(start_go_o, 1'b0)
    ce_i <= 1'b1;
    wr(TWS_OFF_CTRL, 8'h45);
    tws_master_model_inst.bus_start();
    x(8'h00, 1'b1);
    `CHK(ack, 1'b0)
    st(TWS_ST_GC_ADDR);
    wr(TWS_OFF_CTRL, 8'hC5);
    x(8'hA1, 1'b1);
    `CHK(ack, 1'b0)
    st(TWS_ST_GC_ACK);
    wr(TWS_OFF_CTRL, 8'h85);
    x(8'hB2, 1'b1);
    `CHK(ack, 1'b1)
    st(TWS_ST_GC_NACK);
    wr(TWS_OFF_CTRL, 8'hC5);
    x(8'hC3, 1'b1);
    `CHK(ack, 1'b1)
    tws_master_model_inst.bus_stop();
    wr(TWS_OFF_ADDR, 8'h54);
    foreach (bad[i]) begin
      tws_master_model_inst.bus_start();
      x(bad[i], 1'b1);
      `CHK(ack, 1'b1)
      tws_master_model_inst.bus_stop();
    end
    wr(TWS_OFF_CTRL, 8'h05);
    tws_master_model_inst.bus_start();
    x(8'h54, 1'b1);
    `CHK(ack, 1'b1)
    tws_master_model_inst.bus_stop();
    wr(TWS_OFF_CTRL, 8'h45);
    tws_master_model_inst.bus_start();
    x(8'h54, 1'b1);
    `CHK(ack, 1'b0)
    wr(TWS_OFF_CTRL, 8'hC5);
    tws_master_model_inst.bus_stop();
    st(TWS_ST_STOP);
    `CHK(scl_oe_o, 1'b0)
    wr(TWS_OFF_CTRL, 8'hC5);
    arb_lost_i <= 1'b1;
    tws_master_model_inst.bus_start();
    x(8'h55, 1'b1);
    `CHK(ack, 1'b0)
    st(TWS_ST_ST_ARB);
    arb_lost_i <= 1'b0;
    wr(TWS_OFF_DATA, 8'hA6);
    wr(TWS_OFF_CTRL, 8'hC5);
    x(8'hFF, 1'b0);
    `CHK(q, 8'hA6)
    st(TWS_ST_ST_ACK);
    wr(TWS_OFF_DATA, 8'h5B);
    wr(TWS_OFF_CTRL, 8'h85);
    x(8'hFF, 1'b0);
    `CHK(q, 8'h5B)
    st(TWS_ST_ST_LAST);
    wr(TWS_OFF_CTRL, 8'hC5);
    x(8'hFF, 1'b0);
    `CHK(q, 8'hFF)
    tws_master_model_inst.bus_stop();
    tws_master_model_inst.bus_start();
    x(8'h55, 1'b1);
    st(TWS_ST_ST_ADDR);
    wr(TWS_OFF_DATA, 8'h81);
    wr(TWS_OFF_CTRL, 8'h85);
    x(8'hFF, 1'b1);
    `CHK(q, 8'h81)
    st(TWS_ST_ST_NACK);
    wr(TWS_OFF_CTRL, 8'hC5);
    tws_master_model_inst.bus_stop();
    deep_sleep_i <= 1'b1;
    tws_master_model_inst.bus_start();
    x(8'h54, 1'b1);
    `CHK({ack, wake_o, scl_oe_o}, 3'b011)
    deep_sleep_i <= 1'b0;
    st(TWS_ST_SR_ADDR);
    wr(TWS_OFF_CTRL, 8'hC5);
    rd(TWS_OFF_STATUS);
    `CHK({wake_o, scl_oe_o, v}, {2'b00, 8'hF8})
    tws_master_model_inst.bus_stop();
    st(TWS_ST_STOP);
    wr(TWS_OFF_CTRL, 8'hC5);
    complete_run();
  end
endmodule // tb
